// ### verilog/wdt_top.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wdt_top #(
    parameter int TIMEOUT_TICKS = wdt_pkg::TIMEOUT_TICKS
) (
    input  wire  logic        clk,
    input  wire  logic        reset_n,
    input  wire  logic        wdtRcClk,
    input  wire  logic        watchdogEnableFuse,
    input  wire  logic        clearWatchdogInstr,
    input  wire  logic        sleepInstr,
    input  wire  logic        coreSleeping,
    output logic              deviceReset,
    output logic              wakeUp,
    output logic              timeoutFlagN,
    output logic              irq,
    input  wire  logic [11:0] s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    input  wire  logic [11:0] s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready
);

    // ---------------------------------------------------------------
    // overview
    // ---------------------------------------------------------------
    // the block runs on clk only; the rc oscillator is sampled as data
    // and each synchronised rising edge is one watchdog tick.
    // the rc clock must be slower than half of clk, otherwise
    // ticks are lost in the edge detector and the time-out stretches.
    // the base counter wraps after TIMEOUT_TICKS ticks; that alone is
    // the time-out while timer zero owns the prescaler.
    // while the watchdog owns the prescaler, every base wrap advances
    // the postscaler, and the time-out comes when it passes 2**rate-1.
    // the postscaler is eight bits so that rate 7 fits with no carry.
    // a time-out raises one of two one-cycle pulses, never both:
    //   deviceReset when the core is running,
    //   wakeUp when the core reports that it sleeps.
    // the chip reset that deviceReset causes is applied outside; this
    // block keeps its own state, so the time-out flag survives it.
    // the flag goes low on every time-out and back high on a
    // clear-watchdog or sleep instruction, or on reset_n.
    // a fuse at zero holds the base counter at zero, and the postscaler too while the watchdog owns it, so no pulse can
    // follow; the fuse passes two flops, so it acts three cycles late.
    // register map, byte address = index * 4:
    //   option  0x204  bit3 assign, bits2:0 rate, reset 0xff
    //   status  0x208  bit0 reset event, bit1 wake event, write 1 clears
    //   mask    0x20c  same layout as status, reset 0
    //   state   0x210  read only: flag, synced enable, postscaler count
    // only byte lane 0 is written; the upper lanes are ignored.
    // an unmapped or unaligned address answers with slverr.
    localparam int CNT_W = (TIMEOUT_TICKS > 1) ? $clog2(TIMEOUT_TICKS) : 1;
    localparam logic [CNT_W-1:0] LAST_TICK = CNT_W'(TIMEOUT_TICKS - 1);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic                    rcSync1;
        logic                    rcSync2;
        logic                    rcPrev;
        logic                    fuseSync1;
        logic                    fuseSync2;
        logic [CNT_W-1:0]        baseCnt;
        logic [7:0]              postCnt;
        logic [7:0]              option;
        logic                    toFlagN;
        logic                    devRst;
        logic                    wake;
        logic [wdt_pkg::EV_W-1:0] status;
        logic [wdt_pkg::EV_W-1:0] mask;
        logic                    irq;
        logic                    awHave;
        logic                    wHave;
        logic [11:0]             awAddr;
        logic [7:0]              wByte;
        logic                    wLane0;
        logic                    awReady;
        logic                    wReady;
        logic                    bValid;
        logic [1:0]              bResp;
        logic                    arReady;
        logic                    rValid;
        logic [31:0]             rData;
        logic [1:0]              rResp;
    } wdt_state_type;

    wdt_state_type state_r;
    wdt_state_type state_nxt;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // the decode function is shared by the write and read paths; it
    // checks the low address bits first so that a misaligned access
    // never hits a register through the upper bits alone.
    // the last-count function turns the rate code into the final
    // postscaler count; rate 0 gives zero, so every base wrap expires.
    // byte address to register; low two bits must be zero
    function automatic wdt_pkg::wdt_sel_type wdt_decode(input logic [11:0] addr);
        wdt_pkg::wdt_sel_type sel;
        sel = wdt_pkg::WDT_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[11:2])
                wdt_pkg::OPTION_IDX[9:0]: sel = wdt_pkg::WDT_SEL_OPTION;
                wdt_pkg::STATUS_IDX[9:0]: sel = wdt_pkg::WDT_SEL_STATUS;
                wdt_pkg::MASK_IDX[9:0]:   sel = wdt_pkg::WDT_SEL_MASK;
                wdt_pkg::STATE_IDX[9:0]:  sel = wdt_pkg::WDT_SEL_STATE;
                default:                  sel = wdt_pkg::WDT_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : wdt_decode

    // last postscaler count for rate field ps: ratio 2**ps
    function automatic logic [7:0] wdt_post_last(input logic [wdt_pkg::PS_W-1:0] ps);
        return (8'h01 << ps) - 8'h01;
    endfunction : wdt_post_last

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic                     rcTick;
        logic                     enabled;
        logic                     ownPre;
        logic                     restart;
        logic                     expire;
        logic [wdt_pkg::EV_W-1:0] evSet;
        logic [wdt_pkg::EV_W-1:0] evClr;
        wdt_pkg::wdt_sel_type     wSel;
        wdt_pkg::wdt_sel_type     rSel;
        logic                     doWrite;
        rcTick  = 1'b0;
        enabled = 1'b0;
        ownPre  = 1'b0;
        restart = 1'b0;
        expire  = 1'b0;
        evSet   = '0;
        evClr   = '0;
        wSel    = wdt_pkg::WDT_SEL_NONE;
        rSel    = wdt_pkg::WDT_SEL_NONE;
        doWrite = 1'b0;
        state_nxt = state_r;

        // rc clock and fuse come from outside: two flops before use
        state_nxt.rcSync1   = wdtRcClk;
        state_nxt.rcSync2   = state_r.rcSync1;
        state_nxt.rcPrev    = state_r.rcSync2;
        state_nxt.fuseSync1 = watchdogEnableFuse;
        state_nxt.fuseSync2 = state_r.fuseSync1;
        rcTick  = state_r.rcSync2 & ~state_r.rcPrev;
        enabled = state_r.fuseSync2;
        ownPre  = state_r.option[wdt_pkg::OWN_BIT];
        restart = clearWatchdogInstr | sleepInstr;

        // a restart clears the postscaler only while the watchdog
        // owns it; while timer zero owns it the watchdog leaves it
        // alone, so software must clear it there (timer zero is not
        // part of this block).
        // lowering the rate so that its last count is at or below the current
        // postscaler count gives a time-out at the next base wrap (greater-or-equal compare).
        // raising the rate only lengthens the current period.
        // a restart in the cycle of a base wrap wins: the base counter clears, the postscaler only while the watchdog owns it,
        // no time-out is raised and the flag goes high.
        // the base counter counts only synchronised ticks, so a tick
        // that lands in the restart cycle is dropped; the period thus runs from
        // one tick short of nominal up to nominal, never longer.
        // watchdog counter and postscaler
        if (!enabled || restart) begin
            state_nxt.baseCnt = '0;
            if (ownPre) begin
                state_nxt.postCnt = 8'h00;
            end
        end else if (rcTick) begin
            if (state_r.baseCnt == LAST_TICK) begin
                state_nxt.baseCnt = '0;
                if (ownPre) begin
                    if (state_r.postCnt >= wdt_post_last(state_r.option[wdt_pkg::PS_LSB +: wdt_pkg::PS_W])) begin
                        state_nxt.postCnt = 8'h00;
                        expire = 1'b1;
                    end else begin
                        state_nxt.postCnt = state_r.postCnt + 8'h01;
                    end
                end else begin
                    expire = 1'b1;
                end
            end else begin
                state_nxt.baseCnt = state_r.baseCnt + CNT_W'(1);
            end
        end

        // time-out effects: reset when running, wake when asleep
        state_nxt.devRst = expire & ~coreSleeping;
        state_nxt.wake   = expire & coreSleeping;
        if (expire) begin
            state_nxt.toFlagN = 1'b0;
        end else if (restart) begin
            state_nxt.toFlagN = 1'b1;
        end
        evSet[wdt_pkg::EV_RESET] = state_nxt.devRst;
        evSet[wdt_pkg::EV_WAKE]  = state_nxt.wake;

        // write path timing, counted from the edge that takes the later
        // of address and data:
        //   edge 0: address and data held, ready drops
        //   edge 1: register updated, bvalid raised
        //   bvalid stands until an edge with bready high
        // ready stays low from take to response so that a second
        // write cannot overwrite the held address; the cost is two
        // idle cycles between back-to-back writes.
        // both valids in one cycle are taken together; the response
        // then follows one edge after the take.
        // a mapped write with wstrb[0] low answers okay and changes nothing.
        // a status clear and a new event in one cycle keep the event,
        // so software never loses a time-out that it did not see.
        // axi write: address and data taken in either order
        if (s_axi_awvalid && state_r.awReady) begin
            state_nxt.awHave = 1'b1;
            state_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_r.wReady) begin
            state_nxt.wHave  = 1'b1;
            state_nxt.wByte  = s_axi_wdata[7:0];
            state_nxt.wLane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            state_nxt.bValid = 1'b0;
        end
        if (state_r.awHave && state_r.wHave && !state_r.bValid) begin
            wSel    = wdt_decode(state_r.awAddr);
            doWrite = state_r.wLane0;
            state_nxt.awHave = 1'b0;
            state_nxt.wHave  = 1'b0;
            state_nxt.bValid = 1'b1;
            state_nxt.bResp  = (wSel == wdt_pkg::WDT_SEL_NONE) ? wdt_pkg::RESP_SLVERR : wdt_pkg::RESP_OKAY;
            if (doWrite) begin
                case (wSel)
                    wdt_pkg::WDT_SEL_OPTION: state_nxt.option = state_r.wByte;
                    wdt_pkg::WDT_SEL_STATUS: evClr = state_r.wByte[wdt_pkg::EV_W-1:0];
                    wdt_pkg::WDT_SEL_MASK:   state_nxt.mask = state_r.wByte[wdt_pkg::EV_W-1:0];
                    default:                 evClr = '0;
                endcase
            end
        end
        state_nxt.awReady = ~state_nxt.awHave & ~state_nxt.bValid;
        state_nxt.wReady  = ~state_nxt.wHave & ~state_nxt.bValid;

        // sticky events: a set in the clearing cycle wins
        state_nxt.status = (state_r.status & ~evClr) | evSet;
        state_nxt.irq    = |(state_nxt.status & state_nxt.mask);

        // read path: the address is decoded in the cycle it is taken
        // and the data is registered at that edge, so rvalid follows
        // one cycle later; arready stays low while rvalid stands.
        // the data is sampled at the take, not at the rready edge, so
        // a status bit that sets while rvalid waits shows on the next
        // read.
        // an unmapped read answers zero with slverr.
        // reading status does not clear it; only a write of one does.
        // the state register lets software see the fuse as synced.
        // axi read: one cycle from address to data
        if (s_axi_rvalid && s_axi_rready) begin
            state_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && state_r.arReady) begin
            rSel = wdt_decode(s_axi_araddr);
            state_nxt.rValid = 1'b1;
            state_nxt.rResp  = (rSel == wdt_pkg::WDT_SEL_NONE) ? wdt_pkg::RESP_SLVERR : wdt_pkg::RESP_OKAY;
            case (rSel)
                wdt_pkg::WDT_SEL_OPTION: state_nxt.rData = {24'h000000, state_r.option};
                wdt_pkg::WDT_SEL_STATUS: state_nxt.rData = {30'h00000000, state_r.status};
                wdt_pkg::WDT_SEL_MASK:   state_nxt.rData = {30'h00000000, state_r.mask};
                wdt_pkg::WDT_SEL_STATE:  state_nxt.rData = {22'h000000, state_r.postCnt, enabled, state_r.toFlagN};
                default:                 state_nxt.rData = 32'h00000000;
            endcase
        end
        state_nxt.arReady = ~state_nxt.rValid;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // the struct is reset as a whole to zero and then the few fields
    // whose idle level is one are set; nothing here reads state, so
    // the reset branch stays free of data paths.
    // the rc synchroniser resets to zero; the pin must also idle low
    // at reset, or the first edge after reset counts one early tick.
    // reset_n is asynchronous; its release should meet clk timing,
    // which the chip's reset sequencer is expected to provide.
    // all control state takes constants under reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r         <= '0;
            state_r.option  <= wdt_pkg::OPTION_RST;
            state_r.toFlagN <= 1'b1;
            state_r.awReady <= 1'b1;
            state_r.wReady  <= 1'b1;
            state_r.arReady <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // no output is combinational: every port below is a flop of the
    // state struct, so the bus timing above holds at the pins.
    // irq is registered alongside status, so it rises with the event.
    // outputs come straight from the state flops
    assign deviceReset   = state_r.devRst;
    assign wakeUp        = state_r.wake;
    assign timeoutFlagN  = state_r.toFlagN;
    assign irq           = state_r.irq;
    assign s_axi_awready = state_r.awReady;
    assign s_axi_wready  = state_r.wReady;
    assign s_axi_bvalid  = state_r.bValid;
    assign s_axi_bresp   = state_r.bResp;
    assign s_axi_arready = state_r.arReady;
    assign s_axi_rvalid  = state_r.rValid;
    assign s_axi_rdata   = state_r.rData;
    assign s_axi_rresp   = state_r.rResp;

endmodule : wdt_top

// ### verilog/wdt_pkg.sv
package wdt_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int WDT_PERIOD_US = 18000;   // nominal time-out without prescaler
    localparam int RC_FREQ_HZ    = 100000;  // nominal rate of the watchdog rc oscillator
    localparam int TIMEOUT_TICKS = (WDT_PERIOD_US * (RC_FREQ_HZ / 1000)) / 1000;

    // ---------------------------------------------------------------
    // register map (index times four is the byte address)
    // ---------------------------------------------------------------
    localparam logic [11:0] OPTION_IDX  = 12'h081;
    localparam logic [11:0] STATUS_IDX  = 12'h082;
    localparam logic [11:0] MASK_IDX    = 12'h083;
    localparam logic [11:0] STATE_IDX   = 12'h084;
    localparam logic [7:0]  OPTION_RST  = 8'hff;

    // option_control fields
    localparam int OWN_BIT   = 3;  // prescaler_assign_select: 1 = watchdog_unit
    localparam int PS_LSB    = 0;  // prescale_rate_bit0
    localparam int PS_W      = 3;

    // status / mask fields
    localparam int EV_W      = 2;
    localparam int EV_RESET  = 0;  // time-out while running
    localparam int EV_WAKE   = 1;  // time-out while asleep

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register selector returned by the address decoder
    typedef enum logic [2:0] {
        WDT_SEL_NONE,
        WDT_SEL_OPTION,
        WDT_SEL_STATUS,
        WDT_SEL_MASK,
        WDT_SEL_STATE
    } wdt_sel_type;

endpackage : wdt_pkg

// ### testbench/wdt_chk.sv
`timescale 1ns/1ps
module wdt_chk #(
    parameter int TIMEOUT_TICKS = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wdtRcClk,
    input wire logic watchdogEnableFuse,
    input wire logic clearWatchdogInstr,
    input wire logic sleepInstr,
    input wire logic coreSleeping,
    input wire logic deviceReset,
    input wire logic wakeUp,
    input wire logic timeoutFlagN
);
    // --------------------
    // rc ticks since restart
    // --------------------
    int   tickCnt_r;
    logic rcSeen_r;
    // counted from the raw pin, so the design's synchroniser may trail it by a tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_r <= 0;
            rcSeen_r  <= 1'h0;
        end else begin
            rcSeen_r <= wdtRcClk;
            if (clearWatchdogInstr || sleepInstr || deviceReset || wakeUp || !watchdogEnableFuse)
                tickCnt_r <= 0;
            else if (wdtRcClk && !rcSeen_r)
                tickCnt_r <= tickCnt_r + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_reset_pulse: assert property (deviceReset |=> !deviceReset)
        else $error("device reset longer than one cycle");
    chk_reset_awake: assert property (deviceReset |-> !$past(coreSleeping) && !wakeUp)
        else $error("device reset while core asleep");
    chk_wake_asleep: assert property (wakeUp |-> $past(coreSleeping) ##1 !wakeUp)
        else $error("wake pulse without sleep");
    chk_flag_timeout: assert property ((deviceReset || wakeUp) |-> !timeoutFlagN)
        else $error("time-out flag not cleared");
    chk_flag_cause: assert property ($fell(timeoutFlagN) |-> deviceReset || wakeUp)
        else $error("time-out flag dropped without time-out");
    chk_flag_restore: assert property ((clearWatchdogInstr || sleepInstr) |=> timeoutFlagN || deviceReset || wakeUp)
        else $error("flag not restored by instruction");
    chk_fuse_off: assert property (!watchdogEnableFuse [*5] |-> !deviceReset && !wakeUp)
        else $error("time-out with watchdog disabled");
    chk_tout_early: assert property ((deviceReset || wakeUp) |-> tickCnt_r >= TIMEOUT_TICKS - 1)
        else $error("time-out before the base count");
    chk_tout_late: assert property (tickCnt_r <= TIMEOUT_TICKS * 128 + 2)
        else $error("time-out later than the longest ratio");
endmodule : wdt_chk
bind wdt_top wdt_chk #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) wdt_chk_inst (.clk(clk), .reset_n(reset_n),
    .wdtRcClk(wdtRcClk), .watchdogEnableFuse(watchdogEnableFuse), .clearWatchdogInstr(clearWatchdogInstr),
    .sleepInstr(sleepInstr), .coreSleeping(coreSleeping), .deviceReset(deviceReset), .wakeUp(wakeUp),
    .timeoutFlagN(timeoutFlagN));

// ### testbench/wdt_core_model.sv
`timescale 1ns/1ps
module wdt_core_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic doClear,
    input  wire logic doSleep,
    input  wire logic wakeUp,
    input  wire logic deviceReset,
    output logic      clearWatchdogInstr,
    output logic      sleepInstr,
    output logic      coreSleeping
);
    // a sleeping core fetches nothing, so no strobe leaves it until it is woken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clearWatchdogInstr <= 1'h0;
            sleepInstr         <= 1'h0;
            coreSleeping       <= 1'h0;
        end else begin
            clearWatchdogInstr <= doClear && !coreSleeping;
            sleepInstr         <= doSleep && !coreSleeping;
            if (sleepInstr)
                coreSleeping <= 1'h1;
            else if (wakeUp || deviceReset)
                coreSleeping <= 1'h0;
        end
    end
endmodule : wdt_core_model

// ### testbench/wdt_top_bench.sv
`timescale 1ns/1ps
module wdt_top_bench;
    localparam int          TICKS = 4;
    localparam logic [11:0] OPT   = wdt_pkg::OPTION_IDX << 2;
    localparam logic [11:0] STA   = wdt_pkg::STATUS_IDX << 2;
    localparam logic [11:0] MSK   = wdt_pkg::MASK_IDX << 2;
    localparam logic [11:0] STE   = wdt_pkg::STATE_IDX << 2;
    localparam logic [1:0]  OK    = wdt_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR   = wdt_pkg::RESP_SLVERR;
    typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] resp; logic [31:0] rd;} wdt_row_type;
    // reset values, mask access, unmapped and unaligned places
    wdt_row_type rows [6] = '{'{1'h0, OPT, 32'h0, OK, 32'hff}, '{1'h0, MSK, 32'h0, OK, 32'h0},
        '{1'h1, 12'h300, 32'h1, ERR, 32'h0}, '{1'h0, 12'h300, 32'h0, ERR, 32'h0},
        '{1'h0, 12'h205, 32'h0, ERR, 32'h0}, '{1'h1, MSK, 32'h3, OK, 32'h0}};
    logic        clk = 1'h0, reset_n = 1'h0, rcClk = 1'h0, fuse = 1'h1, doClear = 1'h0, doSleep = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [7:0]  opt;
    logic [1:0]  bresp, rresp, rsp;
    logic        clrI, slpI, sleeping, devRst, wake, flagN, irq, awready, wready, bvalid, arready, rvalid;
    int          n_fail = 0, cmp_count = 0, cyc = 0, hits = 0, prev = TICKS * 128;
    always #5 clk = ~clk;
    always #50 rcClk = ~rcClk; // own free-running oscillator, never stopped
    wdt_top #(.TIMEOUT_TICKS(TICKS)) wdt_top_inst (.clk(clk), .reset_n(reset_n), .wdtRcClk(rcClk),
        .watchdogEnableFuse(fuse), .clearWatchdogInstr(clrI), .sleepInstr(slpI), .coreSleeping(sleeping),
        .deviceReset(devRst), .wakeUp(wake), .timeoutFlagN(flagN), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    wdt_core_model wdt_core_model_inst (.clk(clk), .reset_n(reset_n), .doClear(doClear), .doSleep(doSleep),
        .wakeUp(wake), .deviceReset(devRst), .clearWatchdogInstr(clrI), .sleepInstr(slpI), .coreSleeping(sleeping));
    // --------------------
    // bus, timing and report tasks
    // --------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task results;
        $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // each valid drops at the edge that takes it; the extra edge keeps strobes from being set twice at once
    task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
        do begin
            @(posedge clk);
            k++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
        end while (!(wr ? bvalid : rvalid) && k < 100);
        {bready, rready} <= 2'h0;
        rsp = wr ? bresp : rresp;
        rd = rdata;
        if (k >= 100) n_fail++;
        @(posedge clk);
    endtask : axi
    // restart with clear or sleep, then time the expiry in clk cycles (10 per rc tick)
    task automatic expire(input int ticks, input logic asleep);
        int k = 0;
        {doClear, doSleep} <= {!asleep, asleep};
        @(posedge clk);
        {doClear, doSleep} <= 2'h0;
        do begin
            @(posedge clk);
            k++;
        end while (!(devRst || wake) && k < 6000);
        check(32'(k >= (ticks - 1) * 10 && k <= (ticks + 1) * 10 + 10), 32'h1);
        check(32'({devRst, wake, flagN}), 32'({!asleep, asleep, 1'h0}));
        @(posedge clk);
    endtask : expire
    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        check(32'({devRst, wake, flagN, irq}), 32'h2);
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].d);
            check(32'(rsp), 32'(rows[i].resp));
            if (!rows[i].wr) check(rd, rows[i].rd);
        end
        // every rate code with ownership, and codes 0 and 7 without; clear always precedes the reassignment
        for (int r = 0; r < 10; r++) begin
            opt = (r < 2) ? 8'(r * 7) : 8'(r + 6);
            expire(prev, 1'h0);
            axi(1'h1, OPT, {24'h0, opt});
            prev = TICKS * (opt[3] ? 1 << opt[2:0] : 1);
            expire(prev, 1'h0);
        end
        axi(1'h0, STA, 32'h0);
        check(rd, 32'h1);
        check(32'(irq), 32'h1);
        axi(1'h1, STA, 32'h3);
        check(32'(irq), 32'h0);
        axi(1'h1, OPT, 32'h0);
        expire(TICKS, 1'h1);
        for (int i = 0; i < 750; i++) begin
            doClear <= (i % 25 == 0);
            @(posedge clk);
            hits += devRst;
        end
        fuse <= 1'h0;
        check(32'(hits), 32'h0);
        check(32'(flagN), 32'h1);
        axi(1'h0, STA, 32'h0);
        check(rd, 32'h2);
        check(32'(irq), 32'h1);
        axi(1'h1, MSK, 32'h0);
        check(32'(irq), 32'h0);
        axi(1'h1, STA, 32'h3);
        for (int i = 0; i < 600; i++) begin
            @(posedge clk);
            hits += devRst | wake;
        end
        axi(1'h0, STE, 32'h0);
        check(32'(hits), 32'h0);
        check(32'(rd[1:0]), 32'h1);
        fuse <= 1'h1;
        expire(TICKS, 1'h0);
        reset_n <= 1'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        axi(1'h0, OPT, 32'h0);
        check(rd, 32'hff);
        check(32'({devRst, wake, flagN, irq}), 32'h2);
        results();
    end
endmodule : wdt_top_bench
